// ### rst_wdt_pkg.sv
// Shared constants for the reset, watchdog and sleep timer block
package rst_wdt_pkg;
   // Register map
   localparam logic [7:0] ADDR_SLOW_OSC_TRIM  = 8'h36;
   localparam logic [7:0] ADDR_WATCHDOG_CLEAR = 8'hE3;
   localparam logic [7:0] ADDR_SYS_STATUS     = 8'hFF;
   // Trim register fields
   localparam int TRIM_LP_BIT   = 7;
   localparam int TRIM_BIAS_HI  = 5;
   localparam int TRIM_BIAS_LO  = 4;
   localparam int TRIM_FREQ_HI  = 3;
   localparam logic [1:0] BIAS_RESERVED = 2'h2;
   localparam logic [1:0] BIAS_MID      = 2'h0;
   localparam logic [7:0] TRIM_RESET    = 8'h00;
   // Status/control fields
   localparam int SCR_GLOBAL_IRQ_STATUS  = 7;
   localparam int SCR_WATCHDOG_CAUSE_BIT  = 5;
   localparam int SCR_POWERON_CAUSE_BIT  = 4;
   localparam int SCR_SLEEP = 3;
   localparam int SCR_STOP  = 0;
   localparam logic [7:0] SCR_POR_VALUE = 8'h10;
   // Watchdog
   localparam logic [7:0] WDT_FULL_CLEAR = 8'h38;
   localparam logic [1:0] WDT_LIMIT      = 2'h3;
   // Oscillator recovery in slow clock cycles
   localparam logic [1:0] OSC_RECOVER_CYC = 2'h3;
   // Clock select and divide codes, fetch start address
   localparam logic [1:0] CLKSEL_INTERNAL = 2'h0;
   localparam logic [2:0] CPU_DIV_POR     = 3'h7;
   localparam logic [15:0] FETCH_START    = 16'h0000;
   // Power-on hold-off
   localparam int CORE_CLK_HZ   = 10_000_000;
   localparam int HOLDOFF_MS    = 20;
   localparam int HOLDOFF_CYC   = CORE_CLK_HZ / 1000 * HOLDOFF_MS;
   // Sleep timer period selects
   localparam logic [1:0] SLP_SEL_64   = 2'h0;
   localparam logic [1:0] SLP_SEL_512  = 2'h1;
   localparam logic [1:0] SLP_SEL_1024 = 2'h2;
   localparam logic [14:0] SLP_TOP_64   = 15'h003F;
   localparam logic [14:0] SLP_TOP_512  = 15'h01FF;
   localparam logic [14:0] SLP_TOP_1024 = 15'h03FF;
   localparam logic [14:0] SLP_TOP_8192 = 15'h1FFF;
endpackage

// ### slow_tick_sync.sv
// Brings the slow oscillator into the core domain as rising-edge pulses
`timescale 1ns/10ps
`default_nettype none
module slow_tick_sync
   import rst_wdt_pkg::*;
(
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_slow_clk,
   output logic      o_tick
);
   logic meta;
   logic sync;
   logic sync_d;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         meta   <= 1'b0;
         sync   <= 1'b0;
         sync_d <= 1'b0;
      end
      else
      begin
         meta   <= i_slow_clk;
         sync   <= meta;
         sync_d <= sync;
      end
   end

   assign o_tick = sync & ~sync_d;
endmodule
`default_nettype wire

// ### sleep_timer.sv
// Sleep timer counting slow ticks with selectable overflow period
`timescale 1ns/10ps
`default_nettype none
module sleep_timer
   import rst_wdt_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_tick,
   input  wire logic       i_clear,
   input  wire logic [1:0] i_period_sel,
   output logic            o_overflow
);
   logic [14:0] count;
   logic [14:0] top;

   always_comb
   begin
      case (i_period_sel)
         SLP_SEL_64:   top = SLP_TOP_64;
         SLP_SEL_512:  top = SLP_TOP_512;
         SLP_SEL_1024: top = SLP_TOP_1024;
         default:      top = SLP_TOP_8192;
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n || i_clear)
         count <= '0;
      else if (i_tick)
         count <= (count >= top) ? '0 : count + 15'h0001;
   end

   assign o_overflow = i_tick && (count >= top) && !i_clear;
endmodule
`default_nettype wire

// ### reset_status_watchdog_sleep_timer.sv
// Reset cause, status/control, watchdog and sleep-clock control block
// How it works
// - Trim bit 7 selects oscillator low power
// - Two-bit bias field; never write 10b
// - Low nibble held as frequency trim
// - Sleep forces internal clock, stops oscillator
// - Oscillator ready after three slow cycles
// - Any reset restores defaults, masks interrupts
// - Fetch from zero, internal clock after reset
// - Power-on clock is 24 MHz divided by 8
// - Status top bit mirrors global interrupt enable
// - Watchdog cause set by hardware, clear-only
// - Power-on loads 0x10; cause bit clear-only
// - Sleep bit sleeps until interrupt pending
// - Stop bit halts until any reset
// - Hold processor off 20 ms after power-on
// - Clearing power-on bit enables watchdog permanently
// - No watchdog reset while power-on bit set
// - Sleep timer overflow raises its interrupt
// - Three overflows cause watchdog reset
// - Clear write zeroes count; 0x38 clears timer
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module reset_status_watchdog_sleep_timer
   import rst_wdt_pkg::*;
#(
   parameter int HOLDOFF_CYCLES = HOLDOFF_CYC
)
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_slow_clk,
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   input  wire logic        i_global_irq_enable_flag,
   input  wire logic        i_irq_pending,
   input  wire logic [1:0]  i_sleep_period_sel,
   output logic             o_slow_low_power,
   output logic      [1:0]  o_slow_bias,
   output logic      [3:0]  o_slow_freq_trim,
   output logic      [1:0]  o_cpu_clock_select,
   output logic      [2:0]  o_cpu_clock_div,
   output logic             o_fast_osc_run,
   output logic             o_fast_osc_ready,
   output logic             o_cpu_run,
   output logic             o_cpu_sleeping,
   output logic             o_cpu_halted,
   output logic      [15:0] o_fetch_addr,
   output logic             o_irq_disable,
   output logic             o_sleep_timer_irq,
   output logic             o_watchdog_reset_event
);
   typedef enum logic [1:0]
   {
      ST_HOLDOFF = 2'b00,
      ST_RUN     = 2'b01,
      ST_SLEEP   = 2'b10,
      ST_RECOVER = 2'b11
   } cpu_state_e;

   cpu_state_e  state;
   logic [7:0]  trim;
   logic        watchdog_cause_bit;
   logic        poweron_cause_bit;
   logic        sleep_bit;
   logic        stop_bit;
   logic        wdt_enabled;
   logic        wdt_seen;
   logic [1:0]  wdt_count;
   logic [1:0]  recover_cnt;
   logic [31:0] holdoff_cnt;
   logic        slow_tick;
   logic        overflow;
   logic        wr_trim;
   logic        wr_wdc;
   logic        wr_scr;
   logic        wdt_fire;
   logic        soft_rst;
   logic        sys_rst_n;
   logic [7:0]  scr_view;
   logic [7:0]  next_rdata;

   assign wr_trim = i_wr && (i_addr == ADDR_SLOW_OSC_TRIM);
   assign wr_wdc  = i_wr && (i_addr == ADDR_WATCHDOG_CLEAR);
   assign wr_scr  = i_wr && (i_addr == ADDR_SYS_STATUS);

   // Watchdog reset acts as an internal reset in the same cycle
   assign sys_rst_n = i_rst_n && !soft_rst;

   slow_tick_sync u_sync
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_slow_clk (i_slow_clk),
      .o_tick     (slow_tick)
   );

   sleep_timer u_timer
   (
      .i_core_clk   (i_core_clk),
      .i_rst_n      (sys_rst_n),
      .i_tick       (slow_tick),
      .i_clear      (wr_wdc && (i_wdata == WDT_FULL_CLEAR)),
      .i_period_sel (i_sleep_period_sel),
      .o_overflow   (overflow)
   );

   always_ff @(posedge i_core_clk)
   begin
      if (!sys_rst_n)
         trim <= TRIM_RESET;
      else if (wr_trim)
      begin
         // reserved bias code falls back to mid
         if (i_wdata[TRIM_BIAS_HI:TRIM_BIAS_LO] == BIAS_RESERVED)
            trim <= {i_wdata[TRIM_LP_BIT], 1'b0, BIAS_MID, i_wdata[TRIM_FREQ_HI:0]};
         else
            trim <= {i_wdata[TRIM_LP_BIT], 1'b0, i_wdata[TRIM_BIAS_HI:0]};
      end
   end

   assign o_slow_low_power = trim[TRIM_LP_BIT];
   assign o_slow_bias      = trim[TRIM_BIAS_HI:TRIM_BIAS_LO];
   assign o_slow_freq_trim = trim[TRIM_FREQ_HI:0];

   // power-on cause set only by external reset
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         poweron_cause_bit <= 1'b1;
      else if (wr_scr && !i_wdata[SCR_POWERON_CAUSE_BIT])
         poweron_cause_bit <= 1'b0;
   end

   // watchdog cause set by hardware, clear-only
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         watchdog_cause_bit <= 1'b0;
      else if (soft_rst)
         watchdog_cause_bit <= 1'b1;
      else if (wr_scr && !i_wdata[SCR_WATCHDOG_CAUSE_BIT])
         watchdog_cause_bit <= 1'b0;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         wdt_enabled <= 1'b0;
      else if (!poweron_cause_bit)
         wdt_enabled <= 1'b1;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!sys_rst_n)
         sleep_bit <= 1'b0;
      else if (wr_scr)
         sleep_bit <= i_wdata[SCR_SLEEP];
      else if (state == ST_SLEEP && i_irq_pending)
         sleep_bit <= 1'b0;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!sys_rst_n)
         stop_bit <= 1'b0;
      else if (wr_scr && i_wdata[SCR_STOP])
         stop_bit <= 1'b1;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!sys_rst_n || wr_wdc)
         wdt_count <= '0;
      // Idle until enabled, so enabling never fires at once
      else if (overflow && wdt_enabled && wdt_count != WDT_LIMIT)
         wdt_count <= wdt_count + 2'h1;
   end

   assign wdt_fire = wdt_enabled && !poweron_cause_bit && (wdt_count == WDT_LIMIT);

   // Fire pulse registered so the reset is clean and one cycle long
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         soft_rst <= 1'b0;
      else
         soft_rst <= wdt_fire && !soft_rst;
   end

   // Keeps interrupts masked one cycle past the reset pulse
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         wdt_seen <= 1'b0;
      else
         wdt_seen <= soft_rst;
   end

   assign o_watchdog_reset_event = soft_rst;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         state <= ST_HOLDOFF;
      else if (soft_rst)
         state <= ST_RUN;
      else
      begin
         case (state)
            ST_HOLDOFF:
            begin
               if (holdoff_cnt >= 32'(HOLDOFF_CYCLES - 1))
                  state <= ST_RUN;
            end
            ST_RUN:
            begin
               if (wr_scr && i_wdata[SCR_SLEEP])
                  state <= ST_SLEEP;
            end
            ST_SLEEP:
            begin
               if (i_irq_pending)
                  state <= ST_RECOVER;
            end
            ST_RECOVER:
            begin
               if (slow_tick && recover_cnt == OSC_RECOVER_CYC - 2'h1)
                  state <= ST_RUN;
            end
            default: state <= ST_HOLDOFF;
         endcase
      end
   end

   // Watchdog reset skips hold-off, so this runs only after power-on
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         holdoff_cnt <= '0;
      else if (state == ST_HOLDOFF && holdoff_cnt < 32'(HOLDOFF_CYCLES - 1))
         holdoff_cnt <= holdoff_cnt + 32'h1;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n || state != ST_RECOVER)
         recover_cnt <= '0;
      else if (slow_tick)
         recover_cnt <= recover_cnt + 2'h1;
   end

   // internal oscillator forced, stopped in sleep
   assign o_cpu_clock_select = CLKSEL_INTERNAL;
   assign o_fast_osc_run     = (state != ST_SLEEP);
   assign o_fast_osc_ready   = (state == ST_RUN) || (state == ST_HOLDOFF);
   assign o_cpu_clock_div    = CPU_DIV_POR;
   assign o_fetch_addr       = FETCH_START;
   assign o_cpu_halted       = stop_bit;
   assign o_cpu_sleeping     = (state == ST_SLEEP) || (state == ST_RECOVER);
   assign o_cpu_run          = (state == ST_RUN) && !stop_bit && !soft_rst;
   // interrupts disabled through reset and hold-off
   assign o_irq_disable      = (state == ST_HOLDOFF) || soft_rst || wdt_seen;
   assign o_sleep_timer_irq  = overflow;

   assign scr_view = {i_global_irq_enable_flag,
                      1'b0,
                      watchdog_cause_bit,
                      poweron_cause_bit,
                      sleep_bit,
                      2'b00,
                      stop_bit};

   // Write-only and unmapped addresses read as zero
   always_comb
   begin
      next_rdata = '0;
      if (i_rd)
      begin
         case (i_addr)
            ADDR_SLOW_OSC_TRIM: next_rdata = trim;
            ADDR_SYS_STATUS:    next_rdata = scr_view;
            default:            next_rdata = '0;
         endcase
      end
   end

   // Read data stands one cycle only, zero otherwise
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         o_rdata <= '0;
      else
         o_rdata <= next_rdata;
   end
endmodule
`default_nettype wire

// ### rst_wdt_monitor.sv
// Concurrent checks on the ports of the reset and watchdog block
`timescale 1ns/10ps
`default_nettype none
module rst_wdt_monitor
   import rst_wdt_pkg::*;
#(
   parameter int HOLDOFF_CYCLES = HOLDOFF_CYC
)
(
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic [7:0]  i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  o_rdata,
   input wire logic        i_global_irq_enable_flag,
   input wire logic [1:0]  o_slow_bias,
   input wire logic [1:0]  o_cpu_clock_select,
   input wire logic [2:0]  o_cpu_clock_div,
   input wire logic        o_fast_osc_ready,
   input wire logic        o_cpu_run,
   input wire logic        o_cpu_sleeping,
   input wire logic        o_cpu_halted,
   input wire logic [15:0] o_fetch_addr,
   input wire logic        o_irq_disable,
   input wire logic        o_sleep_timer_irq,
   input wire logic        o_watchdog_reset_event
);
   logic        por_set;
   int unsigned hold_cnt;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         por_set <= 1'b1;
      else if (i_wr && i_addr == ADDR_SYS_STATUS && !i_wdata[SCR_POWERON_CAUSE_BIT])
         por_set <= 1'b0;
   end
   // Saturates so a long run never wraps
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         hold_cnt <= 0;
      else if (hold_cnt < HOLDOFF_CYCLES)
         hold_cnt <= hold_cnt + 1;
   end
   a_bias_legal: assert property (o_slow_bias != BIAS_RESERVED)
      else $error("reserved bias code presented");
   a_sleep_clock: assert property (o_cpu_sleeping |-> o_cpu_clock_select == CLKSEL_INTERNAL
      && !o_fast_osc_ready && !o_cpu_run)
      else $error("sleep without forced internal clock");
   a_fetch_zero: assert property (o_fetch_addr == FETCH_START
      && o_cpu_clock_div == CPU_DIV_POR)
      else $error("fetch start or clock divide wrong");
   a_gie_mirror: assert property (i_rd && i_addr == ADDR_SYS_STATUS
      |=> o_rdata[SCR_GLOBAL_IRQ_STATUS] == $past(i_global_irq_enable_flag))
      else $error("status top bit not mirroring flag");
   a_sleep_enter: assert property (i_wr && i_addr == ADDR_SYS_STATUS && i_wdata[SCR_SLEEP]
      && o_cpu_run |=> o_cpu_sleeping)
      else $error("sleep write did not sleep");
   a_stop_halts: assert property (i_wr && i_addr == ADDR_SYS_STATUS && i_wdata[SCR_STOP]
      |=> o_cpu_halted && !o_cpu_run)
      else $error("stop write did not halt");
   a_holdoff_run: assert property (hold_cnt + 2 < HOLDOFF_CYCLES |-> !o_cpu_run)
      else $error("cpu ran during hold-off");
   a_por_no_wdr: assert property (por_set |-> !o_watchdog_reset_event)
      else $error("watchdog reset with power-on bit set");
   a_clear_reads_zero: assert property (i_rd && i_addr == ADDR_WATCHDOG_CLEAR
      |=> o_rdata == 8'h00)
      else $error("write-only register read nonzero");
   a_wdr_masks: assert property (o_watchdog_reset_event |-> ##[0:2] o_irq_disable)
      else $error("interrupts not disabled on watchdog reset");
   a_irq_single: assert property (o_sleep_timer_irq |=> !o_sleep_timer_irq)
      else $error("sleep timer pulse too long");
endmodule
`default_nettype wire

// ### cpu_side_model.sv
// CPU core side: interrupt enable flag and wake interrupt
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model
#(
   parameter int WAKE_DLY = 7
)
(
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_gie,
   input  wire logic i_wake_en,
   input  wire logic i_cpu_sleeping,
   output logic      o_global_irq_enable_flag,
   output logic      o_irq_pending
);
   int wait_cnt;
   // firmware stays on internal clock, no reselect
   always_ff @(posedge i_core_clk)
   begin
      o_global_irq_enable_flag <= i_gie;
      // pending held as a level until awake
      if (!i_rst_n || !i_cpu_sleeping)
      begin
         wait_cnt      <= 0;
         o_irq_pending <= 1'b0;
      end
      else if (i_wake_en && wait_cnt == WAKE_DLY)
         o_irq_pending <= 1'b1;
      else if (i_wake_en)
         wait_cnt <= wait_cnt + 1;
   end
endmodule
`default_nettype wire

// ### reset_status_watchdog_sleep_timer_tb.sv
// Self-checking bench for the reset, watchdog and sleep timer block
`timescale 1ns/10ps
`default_nettype none
module reset_status_watchdog_sleep_timer_tb;
   import rst_wdt_pkg::*;
   localparam int HOLDOFF_CYCLES = 20;
   logic        i_core_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        i_slow_clk = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [1:0]  i_sleep_period_sel = 2'h0;
   logic        gie_req = 1'b0;
   logic        wake_en = 1'b0;
   logic        i_global_irq_enable_flag;
   logic        i_irq_pending;
   logic [7:0]  o_rdata;
   logic        o_slow_low_power;
   logic [1:0]  o_slow_bias;
   logic [3:0]  o_slow_freq_trim;
   logic [1:0]  o_cpu_clock_select;
   logic [2:0]  o_cpu_clock_div;
   logic        o_fast_osc_run;
   logic        o_fast_osc_ready;
   logic        o_cpu_run;
   logic        o_cpu_sleeping;
   logic        o_cpu_halted;
   logic [15:0] o_fetch_addr;
   logic        o_irq_disable;
   logic        o_sleep_timer_irq;
   logic        o_watchdog_reset_event;
   logic [7:0]  d;
   logic [7:0]  r;
   logic [7:0]  trim_m;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          n;
   int          wd_cnt = 0;
   int          per_m[3] = '{64, 512, 1024};
   integer      seed = 82136;
   always #50 i_core_clk = ~i_core_clk;
   // Slow clock runs fast so overflows fit the run
   always #500 i_slow_clk = ~i_slow_clk;
   always @(posedge i_core_clk)
      if (o_watchdog_reset_event)
         wd_cnt <= wd_cnt + 1;
   reset_status_watchdog_sleep_timer #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) uut (.i_core_clk,
      .i_rst_n, .i_slow_clk, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_global_irq_enable_flag, .i_irq_pending, .i_sleep_period_sel, .o_slow_low_power,
      .o_slow_bias, .o_slow_freq_trim, .o_cpu_clock_select, .o_cpu_clock_div,
      .o_fast_osc_run, .o_fast_osc_ready, .o_cpu_run, .o_cpu_sleeping, .o_cpu_halted,
      .o_fetch_addr, .o_irq_disable, .o_sleep_timer_irq, .o_watchdog_reset_event);
   cpu_side_model u_cpu (.i_core_clk, .i_rst_n, .i_gie(gie_req), .i_wake_en(wake_en),
      .i_cpu_sleeping(o_cpu_sleeping), .o_global_irq_enable_flag(i_global_irq_enable_flag),
      .o_irq_pending(i_irq_pending));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge i_core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_core_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= v;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   task automatic do_reset();
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      cyc(4);
      i_rst_n <= 1'b1;
      trim_m = 8'h00;
   endtask
   // Counts cycles up to the next sleep timer pulse
   task automatic gap(output int c);
      c = 0;
      do
      begin
         @(posedge i_core_clk);
         #1 c++;
      end while (!o_sleep_timer_irq && c < 12000);
   endtask
   task automatic results();
      if (error_cnt == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Longest path is about 55k cycles
   initial
   begin
      #9_000_000;
      error_cnt++;
      results();
   end
   initial
   begin
      do_reset();
      cyc(HOLDOFF_CYCLES - 3);
      chk(o_cpu_run, 1'b0);
      cyc(8);
      chk(o_cpu_run, 1'b1);
      gie_req <= 1'b1;
      rd(ADDR_SLOW_OSC_TRIM, r);
      chk(r & 8'hBF, trim_m);
      for (int k = 0; k < 9; k++)
      begin
         d = (k == 0) ? 8'hA5 : 8'($random(seed));
         wr(ADDR_SLOW_OSC_TRIM, d);
         trim_m = d & ((d[5:4] == BIAS_RESERVED) ? 8'h8F : 8'hBF);
         rd(ADDR_SLOW_OSC_TRIM, r);
         chk(r & 8'hBF, trim_m);
         chk({o_slow_low_power, o_slow_bias, o_slow_freq_trim}, {trim_m[7], trim_m[5:0]});
      end
      wr(8'h37, 8'hFF);
      rd(8'h37, r);
      chk(r, 8'h00);
      rd(ADDR_SLOW_OSC_TRIM, r);
      chk(r & 8'hBF, trim_m);
      rd(ADDR_WATCHDOG_CLEAR, r);
      chk(r, 8'h00);
      wr(ADDR_SYS_STATUS, 8'h30);
      rd(ADDR_SYS_STATUS, r);
      chk(r & 8'hB9, 8'h90);
      wr(ADDR_SYS_STATUS, 8'h08);
      cyc(100);
      chk({o_cpu_sleeping, o_fast_osc_run, o_cpu_run}, 3'b100);
      wake_en <= 1'b1;
      n = 0;
      while (!i_irq_pending && n < 100)
      begin
         cyc(1);
         n++;
      end
      n = 0;
      while (!o_cpu_run && n < 200)
      begin
         cyc(1);
         n++;
      end
      chk(n >= 20 && n <= 50, 1'b1);
      wake_en <= 1'b0;
      rd(ADDR_SYS_STATUS, r);
      chk({o_fast_osc_ready, r & 8'h08}, 9'h100);
      wr(ADDR_SYS_STATUS, 8'h01);
      cyc(50);
      chk({o_cpu_halted, o_cpu_run}, 2'b10);
      do_reset();
      cyc(30);
      rd(ADDR_SLOW_OSC_TRIM, r);
      chk({o_cpu_halted, r}, 9'h000);
      for (int k = 0; k < 3; k++)
      begin
         i_sleep_period_sel <= k[1:0];
         gap(n);
         gap(n);
         gap(n);
         chk(n, per_m[k] * 10);
      end
      i_sleep_period_sel <= SLP_SEL_64;
      wr(ADDR_SLOW_OSC_TRIM, 8'h13);
      wr(ADDR_SYS_STATUS, 8'h00);
      repeat (6)
      begin
         cyc(450);
         wr(ADDR_WATCHDOG_CLEAR, 8'($random(seed)));
      end
      chk(wd_cnt, 0);
      wr(ADDR_WATCHDOG_CLEAR, WDT_FULL_CLEAR);
      n = 0;
      while (wd_cnt == 0 && n < 3000)
      begin
         cyc(1);
         n++;
      end
      chk(n >= 1850 && n <= 1990, 1'b1);
      cyc(5);
      rd(ADDR_SYS_STATUS, r);
      chk({o_cpu_run, r & 8'hB9}, 9'h1A0);
      rd(ADDR_SLOW_OSC_TRIM, r);
      chk(r, 8'h00);
      n = 0;
      while (wd_cnt < 2 && n < 3000)
      begin
         cyc(1);
         n++;
      end
      chk(wd_cnt, 2);
      results();
   end
endmodule
bind reset_status_watchdog_sleep_timer rst_wdt_monitor #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) u_mon (
   .i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
   .i_global_irq_enable_flag, .o_slow_bias, .o_cpu_clock_select, .o_cpu_clock_div,
   .o_fast_osc_ready, .o_cpu_run, .o_cpu_sleeping, .o_cpu_halted, .o_fetch_addr,
   .o_irq_disable, .o_sleep_timer_irq, .o_watchdog_reset_event);
`default_nettype wire
